// >>> src/tfhvf_pkg.sv
/*
  Shared constants, types and the timing-word coder for the field, vertical
  and horizontal flag path between a video timing source and the transmitter.
  Assumes a 10-bit word stream at one word per clock.
*/
package tfhvf_pkg;

  localparam logic [9:0]  TRS_ONES      = 10'h3FF;
  localparam logic [9:0]  TRS_ZERO      = 10'h000;
  localparam int          XYZ_F_BIT     = 8;
  localparam int          XYZ_V_BIT     = 7;
  localparam int          XYZ_H_BIT     = 6;
  localparam logic        HCONFIG_RESET = 1'b0;
  localparam logic [9:0]  WORD_RESET    = 10'h000;
  localparam logic [9:0]  BLANK_CHROMA  = 10'h200;
  localparam logic [9:0]  BLANK_LUMA    = 10'h040;

  // Source raster, 10-bit multiplexed standard definition
  localparam logic [10:0] LINE_WORDS    = 11'h6B4;
  localparam logic [10:0] EAV_START     = 11'h5A0;
  localparam logic [10:0] SAV_START     = 11'h6B0;
  localparam logic [10:0] TRS_LEN       = 11'h004;
  localparam logic [9:0]  FRAME_LINES   = 10'h20D;
  localparam logic [9:0]  FIRST_LINE    = 10'h001;
  localparam logic [9:0]  FIELD2_FIRST  = 10'h10A;
  localparam logic [9:0]  V1_LAST       = 10'h013;
  localparam logic [9:0]  V2_FIRST      = 10'h108;
  localparam logic [9:0]  V2_LAST       = 10'h11A;

  typedef enum logic [1:0] {
    TRS_IDLE,
    TRS_SEEN_ONES,
    TRS_SEEN_ZERO1,
    TRS_SEEN_ZERO2
  } tfhvf_trs_type;

  // Fourth timing word with its protection bits
  function automatic logic [9:0] tfhvf_xyz(input logic f, input logic v, input logic h);
    tfhvf_xyz = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h, 2'b00};
  endfunction : tfhvf_xyz

endpackage : tfhvf_pkg

// >>> src/tfhvf_if.sv
/*
  Carrier for the timing flags and the video word they describe.
  Assumes both ends share one clock; the source drives, the device samples.
*/
`timescale 1ns/1ps
interface tfhvf_if;
  logic       fieldId;
  logic       vertBlank;
  logic       horzBlank;
  logic [9:0] videoWord;
  logic       videoValid;

  modport source (
    output fieldId,
    output vertBlank,
    output horzBlank,
    output videoWord,
    output videoValid
  );

  modport device (
    input fieldId,
    input vertBlank,
    input horzBlank,
    input videoWord,
    input videoValid
  );
endinterface : tfhvf_if

// >>> src/tfhvf_source.sv
/*
  Upstream timing generator: walks a fixed raster, emits video words with
  embedded timing words, and drives field, vertical and horizontal flags.
  Assumes the device samples every output on the same rising clock edge.
*/
`timescale 1ns/1ps
module tfhvf_source
  import tfhvf_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic run,
  input  wire logic hConfig,
  input  wire logic progressive,
  tfhvf_if.source   tim
);

  logic [10:0] wordCount_q;
  logic [10:0] wordCount_d;
  logic [9:0]  lineCount_q;
  logic [9:0]  lineCount_d;
  logic [9:0]  word_q;
  logic [9:0]  word_d;
  logic        field_q;
  logic        vert_q;
  logic        horz_q;
  logic        valid_q;

  wire         lineEnd   = (wordCount_q == LINE_WORDS - 11'h001);
  wire         frameEnd  = (lineCount_q == FRAME_LINES);
  wire         inEav     = (wordCount_q >= EAV_START) && (wordCount_q < EAV_START + TRS_LEN);
  wire         inSav     = (wordCount_q >= SAV_START);
  wire         inBlank   = (wordCount_q >= EAV_START);
  wire [10:0]  trsIdx    = inEav ? (wordCount_q - EAV_START) : (wordCount_q - SAV_START);
  // Second field only in interlace; progressive keeps field low
  wire         fieldNow  = !progressive && (lineCount_q >= FIELD2_FIRST);
  wire         vertNow   = (lineCount_q <= V1_LAST) ||
                           (!progressive && lineCount_q >= V2_FIRST && lineCount_q <= V2_LAST);
  // Convention 0 spans both timing words, convention 1 follows the word H bit
  wire         horzNow   = hConfig ? (inBlank && !inSav) : inBlank;
  wire         trsNow    = inEav || inSav;
  wire [9:0]   trsWord   = (trsIdx == 11'h000) ? TRS_ONES :
                           (trsIdx == 11'h003) ? tfhvf_xyz(fieldNow, vertNow, inEav) : TRS_ZERO;
  wire [9:0]   fillWord  = inBlank ? (wordCount_q[0] ? BLANK_LUMA : BLANK_CHROMA)
                                   : {2'b01, wordCount_q[7:0]};

  assign wordCount_d = lineEnd ? 11'h000 : wordCount_q + 11'h001;
  assign lineCount_d = !lineEnd ? lineCount_q : (frameEnd ? FIRST_LINE : lineCount_q + 10'h001);
  assign word_d      = trsNow ? trsWord : fillWord;

  // Flags leave the same flop stage as the word they describe
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wordCount_q <= 11'h000;
      lineCount_q <= FIRST_LINE;
      word_q      <= WORD_RESET;
      field_q     <= 1'b0;
      vert_q      <= 1'b0;
      horz_q      <= 1'b0;
      valid_q     <= 1'b0;
    end else begin
      valid_q <= run;
      if (run) begin
        wordCount_q <= wordCount_d;
        lineCount_q <= lineCount_d;
        word_q      <= word_d;
        field_q     <= fieldNow;
        vert_q      <= vertNow;
        horz_q      <= horzNow;
      end
    end
  end

  assign tim.videoWord  = word_q;
  assign tim.videoValid = valid_q;
  assign tim.fieldId    = field_q;
  assign tim.vertBlank  = vert_q;
  assign tim.horzBlank  = horz_q;

endmodule : tfhvf_source

// >>> src/tfhvf_device.sv
/*
  Transmitter end: finds timing words in the incoming stream and, under
  external timing with processing on, rewrites their F, V and H bits and
  protection bits from the flag inputs. Also keeps the flywheel flags and
  the horizontal timing convention bit of the processing-disable register.
  Assumes flags and words arrive together on the rising clock edge.
*/
`timescale 1ns/1ps

// Overview of operation
// - Field input sets outgoing F bit
// - Source holds field high in second field
// - Field input ignored under embedded timing
// - Vertical input sets outgoing V bit
// - Source holds vertical high over blanking
// - Vertical input ignored under embedded timing
// - Horizontal input sets outgoing H bit
// - Config bit selects horizontal input convention
// - Convention 0 default, spans both timing words
// - Convention 1 follows received H bit
// - Flywheel follows external or embedded timing
module tfhvf_device
  import tfhvf_pkg::*;
(
  input  wire logic  clock,
  input  wire logic  rst,
  tfhvf_if.device    tim,
  input  wire logic  embeddedTimingSelect,
  input  wire logic  ioProcessingEnable,
  input  wire logic  cfgWrite,
  input  wire logic  cfgHConfig,
  output logic       hConfig,
  output logic [9:0] videoOut,
  output logic       videoOutValid,
  output logic       trsRewritten,
  output logic       flywheelField,
  output logic       flywheelVert,
  output logic       flywheelHorz
);

  tfhvf_trs_type trsState_q;
  tfhvf_trs_type trsState_d;
  logic          processingDisableReg_q;
  logic          sawEav_q;
  logic          sawEav_d;
  logic [9:0]    videoOut_q;
  logic [9:0]    videoOut_d;
  logic          videoOutValid_q;
  logic          trsRewritten_q;
  logic          flyField_q;
  logic          flyField_d;
  logic          flyVert_q;
  logic          flyVert_d;
  logic          flyHorz_q;
  logic          flyHorz_d;

  wire [9:0]     wordIn       = tim.videoWord;
  wire           wordValid    = tim.videoValid;
  wire           wordOnes     = (wordIn == TRS_ONES);
  wire           wordZero     = (wordIn == TRS_ZERO);
  wire           isXyz        = wordValid && (trsState_q == TRS_SEEN_ZERO2);
  wire           externalMode = !embeddedTimingSelect;
  // Flag inputs only reach the words in external mode with processing on
  wire           rewriteOn    = externalMode && ioProcessingEnable;
  wire           fieldBit     = tim.fieldId;
  wire           vertBit      = tim.vertBlank;
  // Convention 0: input covers the start word too, so only the first timing word
  // of the blanking run may carry H; convention 1 takes the input as it is
  wire           horzBit      = processingDisableReg_q ? tim.horzBlank
                                                       : (tim.horzBlank && !sawEav_q);
  wire [9:0]     newXyz       = tfhvf_xyz(fieldBit, vertBit, horzBit);
  wire           doRewrite    = isXyz && rewriteOn;

  // Preamble tracking; a run of ones restarts the search
  always_comb begin
    trsState_d = trsState_q;
    if (wordValid) begin
      case (trsState_q)
        TRS_IDLE: begin
          trsState_d = wordOnes ? TRS_SEEN_ONES : TRS_IDLE;
        end
        TRS_SEEN_ONES: begin
          if (wordZero) begin
            trsState_d = TRS_SEEN_ZERO1;
          end else begin
            trsState_d = wordOnes ? TRS_SEEN_ONES : TRS_IDLE;
          end
        end
        TRS_SEEN_ZERO1: begin
          if (wordZero) begin
            trsState_d = TRS_SEEN_ZERO2;
          end else begin
            trsState_d = wordOnes ? TRS_SEEN_ONES : TRS_IDLE;
          end
        end
        TRS_SEEN_ZERO2: begin
          trsState_d = wordOnes ? TRS_SEEN_ONES : TRS_IDLE;
        end
        default: begin
          trsState_d = TRS_IDLE;
        end
      endcase
    end
  end

  // Marks the first timing word inside a horizontal blanking run
  always_comb begin
    sawEav_d = sawEav_q;
    if (wordValid) begin
      if (!tim.horzBlank) begin
        sawEav_d = 1'b0;
      end else if (isXyz) begin
        sawEav_d = 1'b1;
      end
    end
  end

  assign videoOut_d = doRewrite ? newXyz : wordIn;

  // Flywheel flags: external inputs every word, or embedded bits at each timing word
  always_comb begin
    flyField_d = flyField_q;
    flyVert_d  = flyVert_q;
    flyHorz_d  = flyHorz_q;
    if (wordValid) begin
      if (externalMode) begin
        flyField_d = tim.fieldId;
        flyVert_d  = tim.vertBlank;
        flyHorz_d  = tim.horzBlank;
      end else if (isXyz) begin
        flyField_d = wordIn[XYZ_F_BIT];
        flyVert_d  = wordIn[XYZ_V_BIT];
        flyHorz_d  = wordIn[XYZ_H_BIT];
      end
    end
  end

  // Horizontal convention bit, default 0 after reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      processingDisableReg_q <= HCONFIG_RESET;
    end else if (cfgWrite) begin
      processingDisableReg_q <= cfgHConfig;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      trsState_q <= TRS_IDLE;
      sawEav_q   <= 1'b0;
    end else begin
      trsState_q <= trsState_d;
      sawEav_q   <= sawEav_d;
    end
  end

  // One word of latency; words pass through untouched otherwise
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      videoOut_q      <= WORD_RESET;
      videoOutValid_q <= 1'b0;
      trsRewritten_q  <= 1'b0;
    end else begin
      videoOutValid_q <= wordValid;
      trsRewritten_q  <= doRewrite;
      if (wordValid) begin
        videoOut_q <= videoOut_d;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flyField_q <= 1'b0;
      flyVert_q  <= 1'b0;
      flyHorz_q  <= 1'b0;
    end else begin
      flyField_q <= flyField_d;
      flyVert_q  <= flyVert_d;
      flyHorz_q  <= flyHorz_d;
    end
  end

  assign hConfig       = processingDisableReg_q;
  assign videoOut      = videoOut_q;
  assign videoOutValid = videoOutValid_q;
  assign trsRewritten  = trsRewritten_q;
  assign flywheelField = flyField_q;
  assign flywheelVert  = flyVert_q;
  assign flywheelHorz  = flyHorz_q;

endmodule : tfhvf_device

// >>> verif/tfhvf_monitor.sv
/*
  Checker for the device end of the timing-flag carrier.
  Assumes one clock, asynchronous active-high reset, instanced in the bench.
*/
`timescale 1ns/1ps
module tfhvf_monitor
  import tfhvf_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       fieldId,
  input wire logic       vertBlank,
  input wire logic       horzBlank,
  input wire logic [9:0] videoWord,
  input wire logic       videoValid,
  input wire logic       embeddedTimingSelect,
  input wire logic       ioProcessingEnable,
  input wire logic       cfgWrite,
  input wire logic       cfgHConfig,
  input wire logic       hConfig,
  input wire logic [9:0] videoOut,
  input wire logic       videoOutValid,
  input wire logic       trsRewritten,
  input wire logic       flywheelField,
  input wire logic       flywheelVert,
  input wire logic       flywheelHorz
);
  logic [9:0] w1_q;
  logic [9:0] w2_q;
  logic [9:0] w3_q;
  wire        xyzNow = videoValid && w3_q == TRS_ONES && w2_q == TRS_ZERO && w1_q == TRS_ZERO;
  wire        rewriteNow = xyzNow && !embeddedTimingSelect && ioProcessingEnable;
  wire  [2:0] inFlags = videoWord[8:6];
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Invalid words must not shift, or idle gaps would hide a timing word
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      w1_q <= WORD_RESET;
      w2_q <= WORD_RESET;
      w3_q <= WORD_RESET;
    end else if (videoValid) begin
      w1_q <= videoWord;
      w2_q <= w1_q;
      w3_q <= w2_q;
    end
  end
  sequence xyzRewrite;
    rewriteNow;
  endsequence
  sequence xyzKept;
    xyzNow && !rewriteNow;
  endsequence
  chk_f_copy: assert property (xyzRewrite |=> trsRewritten && videoOut[XYZ_F_BIT] == $past(fieldId))
    else $error("F bit not copied");
  chk_v_copy: assert property (xyzRewrite |=> videoOut[XYZ_V_BIT] == $past(vertBlank))
    else $error("V bit not copied");
  chk_h_follow: assert property (xyzRewrite ##0 hConfig |=> videoOut[XYZ_H_BIT] == $past(horzBlank))
    else $error("H bit not copied");
  chk_h_low: assert property (xyzRewrite ##0 !horzBlank |=> !videoOut[XYZ_H_BIT])
    else $error("H bit set while input low");
  // Source embeds H high at the end word and low at the start word
  chk_h_edge: assert property (xyzRewrite ##0 !hConfig |=> videoOut[XYZ_H_BIT] == $past(videoWord[XYZ_H_BIT]))
    else $error("H bit wrong on start or end word");
  chk_word_kept: assert property (xyzKept |=> !trsRewritten && videoOut == $past(videoWord))
    else $error("Timing word altered");
  chk_pulse_cause: assert property (trsRewritten |-> $past(rewriteNow))
    else $error("Rewrite pulse without cause");
  chk_word_delay: assert property (videoValid && !xyzNow |=> videoOutValid && videoOut == $past(videoWord))
    else $error("Word not passed one cycle later");
  chk_fly_ext: assert property (videoValid && !embeddedTimingSelect |=> flywheelField == $past(fieldId)
    && flywheelVert == $past(vertBlank) && flywheelHorz == $past(horzBlank)) else $error("Flywheel not on inputs");
  chk_fly_emb: assert property (xyzNow && embeddedTimingSelect |=>
    {flywheelField, flywheelVert, flywheelHorz} == $past(inFlags)) else $error("Flywheel not on word");
  chk_cfg_load: assert property (cfgWrite |=> hConfig == $past(cfgHConfig))
    else $error("Convention bit not loaded");
  chk_cfg_hold: assert property (!cfgWrite |=> $stable(hConfig))
    else $error("Convention bit moved");
endmodule : tfhvf_monitor

// >>> verif/tb_trs_flag_from_hvf_inputs.sv
/*
  Bench: source and device joined, plus a second device fed by the bench.
  Assumes one 250 MHz clock and the fixed raster of the source.
*/
`timescale 1ns/1ps
module tb_trs_flag_from_hvf_inputs
  import tfhvf_pkg::*;
;
  typedef struct {logic [4:0] m; logic [9:0] x; logic [9:0] e;} tfhvf_row_type;
  // Mode bits: embedded, processing, field, vertical, horizontal
  tfhvf_row_type rows [8] = '{'{5'h09, 10'h3C4, 10'h274}, '{5'h0D, 10'h3C4, 10'h368},
    '{5'h0B, 10'h3C4, 10'h2D8}, '{5'h0E, 10'h3C4, 10'h3B0}, '{5'h08, 10'h3C4, 10'h200},
    '{5'h1F, 10'h274, 10'h274}, '{5'h07, 10'h2D8, 10'h2D8}, '{5'h14, 10'h3C4, 10'h3C4}};
  logic        clock, rst, run, hcSrc, emb, ioEn, cfgW, cfgH, prog;
  logic        hc1, hc2, vld1, vld2, rw1, rw2;
  logic [9:0]  out1, out2, line;
  logic [10:0] pos;
  logic [2:0]  fly1, fly2;
  int          failCount, totalChecks, rwCount;
  tfhvf_if tim();
  tfhvf_if tim2();
  tfhvf_source i_tfhvf_source (.clock(clock), .rst(rst), .run(run), .hConfig(hcSrc), .progressive(prog), .tim(tim));
  tfhvf_device i_tfhvf_device (.clock(clock), .rst(rst), .tim(tim), .embeddedTimingSelect(emb),
    .ioProcessingEnable(ioEn), .cfgWrite(cfgW), .cfgHConfig(cfgH), .hConfig(hc1), .videoOut(out1),
    .videoOutValid(vld1), .trsRewritten(rw1), .flywheelField(fly1[2]), .flywheelVert(fly1[1]), .flywheelHorz(fly1[0]));
  tfhvf_device i_tfhvf_device_b (.clock(clock), .rst(rst), .tim(tim2), .embeddedTimingSelect(emb),
    .ioProcessingEnable(ioEn), .cfgWrite(cfgW), .cfgHConfig(cfgH), .hConfig(hc2), .videoOut(out2),
    .videoOutValid(vld2), .trsRewritten(rw2), .flywheelField(fly2[2]), .flywheelVert(fly2[1]), .flywheelHorz(fly2[0]));
  tfhvf_monitor i_tfhvf_monitor (.clock(clock), .rst(rst), .fieldId(tim.fieldId), .vertBlank(tim.vertBlank),
    .horzBlank(tim.horzBlank), .videoWord(tim.videoWord), .videoValid(tim.videoValid), .embeddedTimingSelect(emb),
    .ioProcessingEnable(ioEn), .cfgWrite(cfgW), .cfgHConfig(cfgH), .hConfig(hc1), .videoOut(out1),
    .videoOutValid(vld1), .trsRewritten(rw1), .flywheelField(fly1[2]), .flywheelVert(fly1[1]), .flywheelHorz(fly1[0]));
  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic testDone();
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : testDone
  task automatic put(input logic [9:0] w, input logic f, input logic v, input logic h);
    @(posedge clock);
    tim2.videoWord <= w;
    tim2.fieldId <= f;
    tim2.vertBlank <= v;
    tim2.horzBlank <= h;
    tim2.videoValid <= 1'h1;
  endtask : put
  // Filler flag hf lets two timing words share one blanking run
  task automatic trs(input logic [4:0] m, input logic [9:0] x, input logic [9:0] e, input logic hf);
    @(posedge clock);
    emb <= m[4];
    ioEn <= m[3];
    put(TRS_ONES, m[2], m[1], m[0]);
    put(TRS_ZERO, m[2], m[1], m[0]);
    put(TRS_ZERO, m[2], m[1], m[0]);
    put(x, m[2], m[1], m[0]);
    put(BLANK_LUMA, m[2], m[1], hf);
    @(negedge clock);
    check(out2, e);
    check(rw2, !m[4] && m[3]);
    check(vld2, 1'h1);
    // Flywheel holds the flags sampled with the timing word, not the filler
    check(fly2, m[4] ? x[8:6] : m[2:0]);
  endtask : trs
  task automatic raster(input int n, input int e, input logic hs, input logic em);
    pos = '0;
    line = FIRST_LINE;
    rwCount = 0;
    @(posedge clock);
    run <= 1'h1;
    hcSrc <= hs;
    emb <= em;
    repeat (n * LINE_WORDS) @(posedge clock);
    run <= 1'h0;
    repeat (4) @(posedge clock);
    check(rwCount, e);
  endtask : raster
  // Wire-side flag levels against the raster position
  // Sampled mid-cycle, where the source flops have settled
  always @(negedge clock) begin
    if (!rst && tim.videoValid) begin
      check(tim.horzBlank, pos >= EAV_START && (hcSrc ? pos < SAV_START : 1'h1));
      check(tim.vertBlank, line <= V1_LAST);
      check(tim.fieldId, 1'h0);
      pos = (pos == LINE_WORDS - 11'h001) ? '0 : pos + 11'h001;
      if (pos == 0)
        line++;
    end
    if (rw1)
      rwCount++;
  end
  initial begin
    repeat (90000) @(posedge clock);
    failCount++;
    testDone();
  end
  initial begin
    {rst, run, hcSrc, emb, ioEn, cfgW, cfgH} = 7'h48;
    {tim2.fieldId, tim2.vertBlank, tim2.horzBlank, tim2.videoValid} = 4'h0;
    tim2.videoWord = 10'h000;
    prog = 1'h0;
    repeat (12) @(posedge clock);
    rst <= 1'h0;
    @(negedge clock);
    check({hc1, out1, vld1, rw1, fly1, hc2, out2, vld2, rw2, fly2}, 32'h0);
    foreach (rows[i]) trs(rows[i].m, rows[i].x, rows[i].e, 1'h0);
    trs(5'h09, 10'h3C4, 10'h274, 1'h1);
    trs(5'h09, 10'h3C4, 10'h200, 1'h0);
    @(posedge clock);
    cfgW <= 1'h1;
    cfgH <= 1'h1;
    @(posedge clock);
    cfgW <= 1'h0;
    @(negedge clock);
    check(hc2, 1'h1);
    trs(5'h09, 10'h3C4, 10'h274, 1'h1);
    trs(5'h09, 10'h3C4, 10'h274, 1'h0);
    raster(2, 4, 1'h1, 1'h0);
    prog <= 1'h1;
    raster(1, 0, 1'h1, 1'h1);
    prog <= 1'h0;
    @(posedge clock);
    rst <= 1'h1;
    repeat (3) @(posedge clock);
    rst <= 1'h0;
    raster(21, 42, 1'h0, 1'h0);
    testDone();
  end
endmodule : tb_trs_flag_from_hvf_inputs
